// ---- core/pshs_consts.svh ----
`ifndef PSHS_CONSTS_SVH
`define PSHS_CONSTS_SVH

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define PSHS_SLOT_CTRL_OFS     12'h0B8
`define PSHS_SLOT_STATUS_OFS   12'h0BA

// ----------------------------------------------------------------
// slot status field positions
// ----------------------------------------------------------------
`define PSHS_BIT_BUTTON        0
`define PSHS_BIT_FAULT         1
`define PSHS_BIT_LATCH         2
`define PSHS_BIT_PRES_CHG      3
`define PSHS_BIT_CMD_DONE      4
`define PSHS_BIT_PRES_STATE    6
`define PSHS_RSVD_HI           15
`define PSHS_RSVD_LO           7

// ----------------------------------------------------------------
// slot control field positions
// ----------------------------------------------------------------
`define PSHS_BIT_PRES_NOTIFY   3

// ----------------------------------------------------------------
// reset values, byte lanes and synchroniser width
// ----------------------------------------------------------------
`define PSHS_STATUS_RESET      16'h0000
`define PSHS_CTRL_RESET        16'h0000
`define PSHS_LANE_LOW          0
`define PSHS_SYNC_WIDTH        4

`endif

// ---- core/pshs_pkg.sv ----
// ----------------------------------------------------------------
// shared types
// ----------------------------------------------------------------
package pshs_pkg;

   // configuration data word, one slot register wide
   typedef logic [15:0] pshs_data_t;

   // configuration byte address
   typedef logic [11:0] pshs_addr_t;

   // byte enables of a 16-bit access
   typedef logic [1:0]  pshs_be_t;

   // positions of the synchronised slot pins
   typedef enum logic [1:0]
   {
      PSHS_PIN_PRESENCE,
      PSHS_PIN_LATCH,
      PSHS_PIN_FAULT,
      PSHS_PIN_BUTTON
   } pshs_pin_t;

endpackage

// ---- core/pshs_pin_sync.sv ----
`timescale 1ns/100ps
// ----------------------------------------------------------------
// three-stage pin synchroniser with agreement filter
// ----------------------------------------------------------------
module pshs_pin_sync
#(
   parameter int WIDTH = 4
)
(
   // clock and reset
   input  wire logic             mclk,
   input  wire logic             rst_n,
   // asynchronous pins
   input  wire logic [WIDTH-1:0] pinAsync,
   // filtered levels
   output logic      [WIDTH-1:0] pinLevel
);

   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_pinLevel;

   // a bit moves only when stages two and three agree; stage one feeds stage two only
   always_comb
   begin
      for (int i = 0; i < WIDTH; i++)
      begin
         next_pinLevel[i] = (stage2[i] == stage3[i]) ? stage3[i] : pinLevel[i];
      end
   end

   // register chain, reset to a quiet slot
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         stage1   <= '0;
         stage2   <= '0;
         stage3   <= '0;
         pinLevel <= '0;
      end
      else
      begin
         stage1   <= pinAsync;
         stage2   <= stage1;
         stage3   <= stage2;
         pinLevel <= next_pinLevel;
      end
   end

endmodule

// ---- core/pshs_slot_status.sv ----
`timescale 1ns/100ps
`include "pshs_consts.svh"
// ----------------------------------------------------------------
// hot-plug slot status register of one downstream root port
// ----------------------------------------------------------------
module pshs_slot_status
(
   // clock and reset
   input  wire logic               mclk,
   input  wire logic               rst_n,
   // configuration access
   input  wire pshs_pkg::pshs_addr_t cfgAddr,
   input  wire logic               cfgWrEn,
   input  wire logic               cfgRdEn,
   input  wire pshs_pkg::pshs_be_t cfgByteEn,
   input  wire pshs_pkg::pshs_data_t cfgWrData,
   output pshs_pkg::pshs_data_t    cfgRdData,
   output logic                    cfgRdValid,
   // slot capability levels
   input  wire logic               slotImplemented,
   input  wire logic               cmdDoneSupported,
   input  wire logic               latchSensorPresent,
   input  wire logic               powerFaultSupported,
   input  wire logic               buttonPresent,
   // hot-plug controller and link, same clock
   input  wire logic               inbandPresence,
   input  wire logic               cmdDonePulse,
   // slot pins, asynchronous
   input  wire logic               presencePin,
   input  wire logic               retentionLatchPin,
   input  wire logic               powerFaultPin,
   input  wire logic               buttonPin,
   // software notification
   output logic                    presenceNotify
);

   import pshs_pkg::*;

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic [`PSHS_SYNC_WIDTH-1:0] pinRaw;
   logic [`PSHS_SYNC_WIDTH-1:0] pinLevel;

   logic       primed;
   logic       presenceState;
   logic       latchPrev;
   logic       faultPrev;
   logic       buttonPrev;
   logic       next_primed;
   logic       next_presenceState;
   logic       next_latchPrev;
   logic       next_faultPrev;
   logic       next_buttonPrev;

   logic       presenceNow;
   logic       presenceEvt;
   logic       latchEvt;
   logic       faultEvt;
   logic       buttonEvt;
   logic       cmdEvt;

   logic       flagButton;
   logic       flagFault;
   logic       flagLatch;
   logic       flagPresChg;
   logic       flagCmdDone;
   logic       next_flagButton;
   logic       next_flagFault;
   logic       next_flagLatch;
   logic       next_flagPresChg;
   logic       next_flagCmdDone;

   logic       notifyEn;
   logic       next_notifyEn;
   logic       next_presenceNotify;

   logic       statusHit;
   logic       ctrlHit;
   logic       statusWrite;
   logic       ctrlWrite;
   pshs_data_t clearMask;
   pshs_data_t statusWord;
   pshs_data_t ctrlWord;
   pshs_data_t next_cfgRdData;
   logic       next_cfgRdValid;

   // ----------------------------------------------------------------
   // pin synchronisation
   // ----------------------------------------------------------------

   // pack the slot pins in enum order
   always_comb
   begin
      pinRaw                    = '0;
      pinRaw[PSHS_PIN_PRESENCE] = presencePin;
      pinRaw[PSHS_PIN_LATCH]    = retentionLatchPin;
      pinRaw[PSHS_PIN_FAULT]    = powerFaultPin;
      pinRaw[PSHS_PIN_BUTTON]   = buttonPin;
   end

   // slow mechanical pins bounce, so the agreement filter also rejects one-cycle glitches
   pshs_pin_sync
   #(
      .WIDTH    (`PSHS_SYNC_WIDTH)
   )
   u_pin_sync
   (
      .mclk     (mclk),
      .rst_n    (rst_n),
      .pinAsync (pinRaw),
      .pinLevel (pinLevel)
   );

   // ----------------------------------------------------------------
   // presence state and event detection
   // ----------------------------------------------------------------

   always_comb
   begin
      if (slotImplemented)
      begin
         presenceNow = inbandPresence | pinLevel[PSHS_PIN_PRESENCE];
      end
      else
      begin
         presenceNow = 1'b1;
      end
   end

   // presence change detect
   // first cycle after reset only loads history, so a card seen in-band at reset raises no false change; a card on the pin still raises one once synchronised
   always_comb
   begin
      presenceEvt = primed & (presenceNow != presenceState);
   end

   always_comb
   begin
      latchEvt = latchSensorPresent & primed & (pinLevel[PSHS_PIN_LATCH] != latchPrev);
   end

   // fault onset detect
   // a fault counts regardless of slot power or occupancy
   always_comb
   begin
      faultEvt = powerFaultSupported & primed & pinLevel[PSHS_PIN_FAULT] & ~faultPrev;
   end

   always_comb
   begin
      buttonEvt = buttonPresent & primed & pinLevel[PSHS_PIN_BUTTON] & ~buttonPrev;
   end

   always_comb
   begin
      cmdEvt = cmdDoneSupported & cmdDonePulse;
   end

   // next values of the history
   always_comb
   begin
      next_primed        = 1'b1;
      next_presenceState = presenceNow;
      next_latchPrev     = pinLevel[PSHS_PIN_LATCH];
      next_faultPrev     = pinLevel[PSHS_PIN_FAULT];
      next_buttonPrev    = pinLevel[PSHS_PIN_BUTTON];
   end

   // history registers
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         primed        <= 1'b0;
         presenceState <= 1'b0;
         latchPrev     <= 1'b0;
         faultPrev     <= 1'b0;
         buttonPrev    <= 1'b0;
      end
      else
      begin
         primed        <= next_primed;
         presenceState <= next_presenceState;
         latchPrev     <= next_latchPrev;
         faultPrev     <= next_faultPrev;
         buttonPrev    <= next_buttonPrev;
      end
   end

   // ----------------------------------------------------------------
   // configuration decode
   // ----------------------------------------------------------------

   // both registers sit in the low byte lane, the high lane holds reserved bits only
   always_comb
   begin
      statusHit   = (cfgAddr == `PSHS_SLOT_STATUS_OFS);
      ctrlHit     = (cfgAddr == `PSHS_SLOT_CTRL_OFS);
      statusWrite = cfgWrEn & statusHit & cfgByteEn[`PSHS_LANE_LOW];
      ctrlWrite   = cfgWrEn & ctrlHit & cfgByteEn[`PSHS_LANE_LOW];
   end

   always_comb
   begin
      clearMask = '0;
      if (statusWrite)
      begin
         clearMask[`PSHS_BIT_BUTTON]   = cfgWrData[`PSHS_BIT_BUTTON];
         clearMask[`PSHS_BIT_FAULT]    = cfgWrData[`PSHS_BIT_FAULT];
         clearMask[`PSHS_BIT_LATCH]    = cfgWrData[`PSHS_BIT_LATCH];
         clearMask[`PSHS_BIT_PRES_CHG] = cfgWrData[`PSHS_BIT_PRES_CHG];
         clearMask[`PSHS_BIT_CMD_DONE] = cfgWrData[`PSHS_BIT_CMD_DONE];
      end
   end

   // ----------------------------------------------------------------
   // sticky flags
   // ----------------------------------------------------------------

   always_comb
   begin
      next_flagButton  = buttonEvt | (flagButton & ~clearMask[`PSHS_BIT_BUTTON]);
      next_flagFault   = faultEvt | (flagFault & ~clearMask[`PSHS_BIT_FAULT]);
      next_flagLatch   = latchEvt | (flagLatch & ~clearMask[`PSHS_BIT_LATCH]);
      next_flagPresChg = presenceEvt | (flagPresChg & ~clearMask[`PSHS_BIT_PRES_CHG]);
      next_flagCmdDone = cmdEvt | (flagCmdDone & ~clearMask[`PSHS_BIT_CMD_DONE]);
      if (!cmdDoneSupported)
      begin
         next_flagCmdDone = 1'b0;
      end
      if (!latchSensorPresent)
      begin
         next_flagLatch = 1'b0;
      end
      if (!powerFaultSupported)
      begin
         next_flagFault = 1'b0;
      end
      if (!buttonPresent)
      begin
         next_flagButton = 1'b0;
      end
   end

   // flag registers
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         flagButton  <= 1'(`PSHS_STATUS_RESET >> `PSHS_BIT_BUTTON);
         flagFault   <= 1'(`PSHS_STATUS_RESET >> `PSHS_BIT_FAULT);
         flagLatch   <= 1'(`PSHS_STATUS_RESET >> `PSHS_BIT_LATCH);
         flagPresChg <= 1'(`PSHS_STATUS_RESET >> `PSHS_BIT_PRES_CHG);
         flagCmdDone <= 1'(`PSHS_STATUS_RESET >> `PSHS_BIT_CMD_DONE);
      end
      else
      begin
         flagButton  <= next_flagButton;
         flagFault   <= next_flagFault;
         flagLatch   <= next_flagLatch;
         flagPresChg <= next_flagPresChg;
         flagCmdDone <= next_flagCmdDone;
      end
   end

   // ----------------------------------------------------------------
   // presence change notification
   // ----------------------------------------------------------------

   // only the presence change enable is kept here; other control bits live elsewhere
   always_comb
   begin
      next_notifyEn = notifyEn;
      if (ctrlWrite)
      begin
         next_notifyEn = cfgWrData[`PSHS_BIT_PRES_NOTIFY];
      end
   end

   // gated notification
   // one pulse per change; a change while disabled is only visible in the flag
   always_comb
   begin
      next_presenceNotify = presenceEvt & notifyEn;
   end

   // notification registers
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         notifyEn       <= 1'(`PSHS_CTRL_RESET >> `PSHS_BIT_PRES_NOTIFY);
         presenceNotify <= 1'b0;
      end
      else
      begin
         notifyEn       <= next_notifyEn;
         presenceNotify <= next_presenceNotify;
      end
   end

   // ----------------------------------------------------------------
   // read path
   // ----------------------------------------------------------------

   always_comb
   begin
      statusWord                        = '0;
      statusWord[`PSHS_BIT_BUTTON]      = flagButton;
      statusWord[`PSHS_BIT_FAULT]       = flagFault;
      statusWord[`PSHS_BIT_LATCH]       = flagLatch;
      statusWord[`PSHS_BIT_PRES_CHG]    = flagPresChg;
      statusWord[`PSHS_BIT_CMD_DONE]    = flagCmdDone;
      statusWord[`PSHS_BIT_PRES_STATE]  = presenceState;
      ctrlWord                          = '0;
      ctrlWord[`PSHS_BIT_PRES_NOTIFY]   = notifyEn;
   end

   // unmapped offsets and disabled lanes read as zero
   always_comb
   begin
      next_cfgRdValid = cfgRdEn;
      next_cfgRdData  = cfgRdData;
      if (cfgRdEn)
      begin
         if (statusHit)
         begin
            next_cfgRdData = statusWord;
         end
         else if (ctrlHit)
         begin
            next_cfgRdData = ctrlWord;
         end
         else
         begin
            next_cfgRdData = '0;
         end
         for (int b = 0; b < 2; b++)
         begin
            if (!cfgByteEn[b])
            begin
               next_cfgRdData[b*8 +: 8] = 8'h00;
            end
         end
      end
   end

   // read registers, data holds until the next read
   always_ff @(posedge mclk)
   begin
      if (!rst_n)
      begin
         cfgRdData  <= `PSHS_STATUS_RESET;
         cfgRdValid <= 1'b0;
      end
      else
      begin
         cfgRdData  <= next_cfgRdData;
         cfgRdValid <= next_cfgRdValid;
      end
   end

endmodule

// ---- test/pshs_slot_status_assertions.sv ----
`timescale 1ns/100ps
`include "pshs_consts.svh"
// ----------------------------------------------------------------
// port checker of the slot status register
// ----------------------------------------------------------------
module pshs_slot_status_assertions
(
   // clock and reset
   input wire logic                 mclk,
   input wire logic                 rst_n,
   // configuration access
   input wire pshs_pkg::pshs_addr_t cfgAddr,
   input wire logic                 cfgWrEn,
   input wire logic                 cfgRdEn,
   input wire pshs_pkg::pshs_be_t   cfgByteEn,
   input wire pshs_pkg::pshs_data_t cfgWrData,
   input wire pshs_pkg::pshs_data_t cfgRdData,
   input wire logic                 cfgRdValid,
   // capabilities and events
   input wire logic                 slotImplemented,
   input wire logic                 cmdDoneSupported,
   input wire logic                 latchSensorPresent,
   input wire logic                 powerFaultSupported,
   input wire logic                 buttonPresent,
   input wire logic                 inbandPresence,
   input wire logic                 cmdDonePulse,
   input wire logic                 presenceNotify
);
   import pshs_pkg::*;
   logic statRd;
   logic notifyEn;
   // shadow of the read target and of the notify enable
   always_ff @(posedge mclk)
   begin
      statRd <= cfgRdEn && cfgAddr == `PSHS_SLOT_STATUS_OFS && cfgByteEn[0];
      if (!rst_n)
         notifyEn <= 1'h0;
      else if (cfgWrEn && cfgAddr == `PSHS_SLOT_CTRL_OFS && cfgByteEn[0])
         notifyEn <= cfgWrData[`PSHS_BIT_PRES_NOTIFY];
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);
   a_rsvd_read_zero: assert property (cfgRdEn |=> cfgRdValid && cfgRdData[15:7] == 9'h000
      && !cfgRdData[5]) else $error("reserved bits not zero or read unanswered");
   a_valid_needs_read: assert property (cfgRdValid |-> $past(cfgRdEn))
      else $error("read valid without a read");
   a_inband_shows_state: assert property (cfgRdValid && statRd && $past(inbandPresence, 2)
      && $past(rst_n, 3) |-> cfgRdData[6]) else $error("in-band presence not reported");
   a_no_slot_present: assert property (cfgRdValid && statRd && !$past(slotImplemented, 2)
      && $past(rst_n, 3) |-> cfgRdData[6]) else $error("slotless port not present");
   a_cmd_done_set: assert property ((cmdDonePulse && cmdDoneSupported) ##1 (cfgRdEn
      && cfgAddr == `PSHS_SLOT_STATUS_OFS && cfgByteEn[0]) |=> cfgRdValid && cfgRdData[4])
      else $error("command done not set");
   a_cmd_unsupported: assert property (cfgRdValid && statRd && !$past(cmdDoneSupported, 2)
      |-> !cfgRdData[4]) else $error("command done set without support");
   a_latch_unsupported: assert property (cfgRdValid && statRd
      && !$past(latchSensorPresent, 2) |-> !cfgRdData[2]) else $error("latch flag without sensor");
   a_fault_unsupported: assert property (cfgRdValid && statRd
      && !$past(powerFaultSupported, 2) |-> !cfgRdData[1]) else $error("fault flag unsupported");
   a_button_unsupported: assert property (cfgRdValid && statRd
      && !$past(buttonPresent, 2) |-> !cfgRdData[0]) else $error("button flag without button");
   a_notify_needs_en: assert property (presenceNotify |-> $past(notifyEn))
      else $error("presence notify while disabled");
endmodule
bind pshs_slot_status pshs_slot_status_assertions chk_u
(
   .mclk(mclk), .rst_n(rst_n), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
   .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
   .cfgRdValid(cfgRdValid), .slotImplemented(slotImplemented),
   .cmdDoneSupported(cmdDoneSupported), .latchSensorPresent(latchSensorPresent),
   .powerFaultSupported(powerFaultSupported), .buttonPresent(buttonPresent),
   .inbandPresence(inbandPresence), .cmdDonePulse(cmdDonePulse),
   .presenceNotify(presenceNotify)
);

// ---- test/test_pshs_slot_status.sv ----
`timescale 1ns/100ps
`include "pshs_consts.svh"
module test_pshs_slot_status;
   import pshs_pkg::*;
   // ----------------------------------------------------------------
   // bench signals
   // ----------------------------------------------------------------
   logic       mclk, rst_n, cfgWrEn, cfgRdEn, cfgRdValid, presenceNotify;
   logic       slotImplemented, cmdDoneSupported, latchSensorPresent;
   logic       powerFaultSupported, buttonPresent, inbandPresence, cmdDonePulse;
   logic       presencePin, retentionLatchPin, powerFaultPin, buttonPin;
   pshs_addr_t cfgAddr;
   pshs_be_t   cfgByteEn;
   pshs_data_t cfgWrData, cfgRdData;
   logic [2:0] caps;
   int         errors, checks, notifyCount, k;
   pshs_slot_status dut_u
   (
      .mclk(mclk), .rst_n(rst_n), .cfgAddr(cfgAddr), .cfgWrEn(cfgWrEn), .cfgRdEn(cfgRdEn),
      .cfgByteEn(cfgByteEn), .cfgWrData(cfgWrData), .cfgRdData(cfgRdData),
      .cfgRdValid(cfgRdValid), .slotImplemented(slotImplemented),
      .cmdDoneSupported(cmdDoneSupported), .latchSensorPresent(latchSensorPresent),
      .powerFaultSupported(powerFaultSupported), .buttonPresent(buttonPresent),
      .inbandPresence(inbandPresence), .cmdDonePulse(cmdDonePulse),
      .presencePin(presencePin), .retentionLatchPin(retentionLatchPin),
      .powerFaultPin(powerFaultPin), .buttonPin(buttonPin), .presenceNotify(presenceNotify)
   );
   // 125 MHz core clock
   initial
   begin
      mclk = 1'h0;
      forever #4 mclk = ~mclk;
   end
   // count notification pulses, they last one cycle each
   always @(posedge mclk)
      if (presenceNotify === 1'h1)
         notifyCount++;
   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic pshs_data_t stat(input logic pres, input logic [4:0] fl);
      return {9'h000, pres, 1'h0, fl};
   endfunction
   task automatic check(input pshs_data_t got, input pshs_data_t exp);
      checks++;
      if (got !== exp)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   // caller leaves a cycle before the next write
   task automatic wr(input pshs_addr_t a, input pshs_be_t be, input pshs_data_t d);
      cfgAddr = a;
      cfgByteEn = be;
      cfgWrData = d;
      cfgWrEn = 1'h1;
      cyc(1);
      cfgWrEn = 1'h0;
   endtask
   // bounded wait on the read answer
   task automatic rd(input pshs_addr_t a, input pshs_data_t exp);
      int n;
      cfgAddr = a;
      cfgByteEn = 2'h3;
      cfgRdEn = 1'h1;
      cyc(1);
      cfgRdEn = 1'h0;
      for (n = 0; n < 4 && cfgRdValid !== 1'h1; n++)
         cyc(1);
      if (n == 4)
      begin
         errors++;
         $display("unexpected at %0t: got %h expected %h", $time, cfgRdValid, 1'h1);
         end_sim();
      end
      else
         check(cfgRdData, exp);
      cyc(1);
   endtask
   task automatic end_sim();
      if (errors == 0 && checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial
   begin
      {rst_n, cfgWrEn, cfgRdEn, cmdDonePulse, inbandPresence} = 5'h00;
      {presencePin, retentionLatchPin, powerFaultPin, buttonPin} = 4'h0;
      {slotImplemented, cmdDoneSupported, latchSensorPresent} = 3'h7;
      {powerFaultSupported, buttonPresent} = 2'h3;
      cfgAddr = 12'h000;
      cfgByteEn = 2'h0;
      cfgWrData = 16'h0000;
      errors = 0;
      checks = 0;
      notifyCount = 0;
      void'($urandom(20));
      cyc(4);
      rst_n = 1'h1;
      cyc(2);
      rd(`PSHS_SLOT_STATUS_OFS, `PSHS_STATUS_RESET);
      rd(`PSHS_SLOT_CTRL_OFS, `PSHS_CTRL_RESET);
      // read-only places ignore writes, unmapped reads zero
      wr(`PSHS_SLOT_STATUS_OFS, 2'h3, 16'hFFFF);
      rd(`PSHS_SLOT_STATUS_OFS, 16'h0000);
      rd(12'h0BC, 16'h0000);
      // card arrives in-band with notification on
      wr(`PSHS_SLOT_CTRL_OFS, 2'h1, 16'h0008);
      rd(`PSHS_SLOT_CTRL_OFS, 16'h0008);
      inbandPresence = 1'h1;
      cyc(1);
      check({15'h0000, presenceNotify}, 16'h0001);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h1, 5'h08));
      wr(`PSHS_SLOT_STATUS_OFS, 2'h2, 16'h0008);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h1, 5'h08));
      wr(`PSHS_SLOT_STATUS_OFS, 2'h1, 16'h0000);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h1, 5'h08));
      wr(`PSHS_SLOT_STATUS_OFS, 2'h1, 16'h0008);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h1, 5'h00));
      // pin takes over, then card leaves with notification off
      presencePin = 1'h1;
      cyc(8);
      inbandPresence = 1'h0;
      wr(`PSHS_SLOT_CTRL_OFS, 2'h1, 16'h0000);
      cyc(2);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h1, 5'h00));
      presencePin = 1'h0;
      cyc(8);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h0, 5'h08));
      // slotless port always reports a card
      wr(`PSHS_SLOT_STATUS_OFS, 2'h1, 16'h0008);
      slotImplemented = 1'h0;
      cyc(2);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h1, 5'h08));
      slotImplemented = 1'h1;
      cyc(2);
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h0, 5'h08));
      check(16'(notifyCount), 16'h0001);
      wr(`PSHS_SLOT_STATUS_OFS, 2'h1, 16'h001F);
      // command done, set beating a clear in the same cycle
      cmdDonePulse = 1'h1;
      cyc(1);
      cmdDonePulse = 1'h0;
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h0, 5'h10));
      cmdDonePulse = 1'h1;
      wr(`PSHS_SLOT_STATUS_OFS, 2'h1, 16'h0010);
      cmdDonePulse = 1'h0;
      rd(`PSHS_SLOT_STATUS_OFS, stat(1'h0, 5'h10));
      cmdDoneSupported = 1'h0;
      cyc(1);
      cmdDonePulse = 1'h1;
      cyc(1);
      cmdDonePulse = 1'h0;
      rd(`PSHS_SLOT_STATUS_OFS, 16'h0000);
      cmdDoneSupported = 1'h1;
      // random sensor pulses under random capabilities
      for (int r = 0; r < 12; r++)
      begin
         caps = 3'($urandom);
         k = $urandom_range(2, 0);
         {latchSensorPresent, powerFaultSupported, buttonPresent} = caps;
         {retentionLatchPin, powerFaultPin, buttonPin} = 3'h1 << k;
         cyc(8);
         {retentionLatchPin, powerFaultPin, buttonPin} = 3'h0;
         cyc(8);
         rd(`PSHS_SLOT_STATUS_OFS, stat(1'h0, {2'h0, caps & (3'h1 << k)}));
         wr(`PSHS_SLOT_STATUS_OFS, 2'h1, 16'h0007);
      end
      cyc(2);
      end_sim();
   end
endmodule
